// ---- src/dac_cfg_pkg.sv ----
package dac_cfg_pkg;
  // Register offsets on the serial configuration port
  localparam logic [6:0]  DP_CTRL_ADDR    = 7'h02;
  localparam logic [6:0]  OUT_CTRL_ADDR   = 7'h03;
  // Reset values and writable bit masks
  localparam logic [15:0] DP_CTRL_RESET   = 16'h7000;
  localparam logic [15:0] OUT_CTRL_RESET  = 16'hf000;
  localparam logic [15:0] DP_CTRL_MASK    = 16'hf0fa;
  localparam logic [15:0] OUT_CTRL_MASK   = 16'hf001;
  // Datapath control field positions
  localparam int WORD_WIDE_BIT      = 15;
  localparam int DACCLK_MUTE_BIT    = 14;
  localparam int DATACLK_MUTE_BIT   = 13;
  localparam int COLLISION_MUTE_BIT = 12;
  localparam int FOUR_WIRE_BIT      = 7;
  localparam int MIXER_ENA_BIT      = 6;
  localparam int MIXER_GAIN_BIT     = 5;
  localparam int NCO_ENA_BIT        = 4;
  localparam int REV_BUS_BIT        = 3;
  localparam int TWOS_BIT           = 1;
  // Output control field positions
  localparam int FS_STEP_MSB        = 15;
  localparam int FS_STEP_LSB        = 12;
  localparam int SW_TX_BIT          = 0;
  // Alarm mask bit positions
  localparam int MASK_COLLISION_BIT = 13;
  localparam int MASK_DACCLK_BIT    = 10;
  localparam int MASK_DATACLK_BIT   = 9;
  localparam int MASK_OUTPUT_BIT    = 8;
  // Codes and serial frame layout
  localparam logic [15:0] MIDSCALE_CODE  = 16'h8000;
  localparam logic [4:0]  INSTR_BITS     = 5'h08;
  localparam logic [4:0]  FRAME_BITS     = 5'h18;
endpackage

// ---- src/sif_slave.sv ----
`timescale 1ns/10ps
module sif_slave (
  input  wire logic        mclk_in,
  input  wire logic        sys_rst_in,
  input  wire logic        sclk_in,
  input  wire logic        sden_n_in,
  input  wire logic        sdio_in,
  output logic             sdio_out,
  output logic             sdio_oe_out,
  output logic             sdo_out,
  output logic             sdo_oe_out,
  input  wire logic        four_wire_in,
  input  wire logic [15:0] rdata_in,
  output logic             wr_out,
  output logic [6:0]       addr_out,
  output logic [15:0]      wdata_out
);
  logic [2:0]  sclk_sync_reg;
  logic [2:0]  sden_sync_reg;
  logic [2:0]  sdio_sync_reg;
  logic        sclk_lvl_reg;
  logic        sden_lvl_reg;
  logic        sclk_rise;
  logic        sclk_fall;
  logic [4:0]  bit_cnt_reg;
  logic        read_reg;
  logic [15:0] shift_in_reg;
  logic [15:0] shift_out_reg;
  logic        drive_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Three-stage synchronisers; stage one feeds only stage two
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      sclk_sync_reg <= 3'h0;
      sden_sync_reg <= 3'h7;
      sdio_sync_reg <= 3'h0;
    end else begin
      sclk_sync_reg <= {sclk_sync_reg[1:0], sclk_in};
      sden_sync_reg <= {sden_sync_reg[1:0], sden_n_in};
      sdio_sync_reg <= {sdio_sync_reg[1:0], sdio_in};
    end
  end

  // Accept a level change only once stages two and three agree
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      sclk_lvl_reg <= 1'b0;
      sden_lvl_reg <= 1'b1;
    end else begin
      if (sclk_sync_reg[1] == sclk_sync_reg[2]) sclk_lvl_reg <= sclk_sync_reg[2];
      if (sden_sync_reg[1] == sden_sync_reg[2]) sden_lvl_reg <= sden_sync_reg[2];
    end
  end

  assign sclk_rise = (sclk_sync_reg[1] == sclk_sync_reg[2]) && sclk_sync_reg[2] && !sclk_lvl_reg;
  assign sclk_fall = (sclk_sync_reg[1] == sclk_sync_reg[2]) && !sclk_sync_reg[2] && sclk_lvl_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Frame: instruction byte (read flag, 7-bit address), then 16 data bits
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      bit_cnt_reg  <= 5'h00;
      read_reg     <= 1'b0;
      shift_in_reg <= 16'h0000;
      addr_out     <= 7'h00;
      wdata_out    <= 16'h0000;
      wr_out       <= 1'b0;
    end else begin
      wr_out <= 1'b0;
      if (sden_lvl_reg) begin
        bit_cnt_reg <= 5'h00;
      end else if (sclk_rise && bit_cnt_reg != dac_cfg_pkg::FRAME_BITS) begin
        bit_cnt_reg  <= bit_cnt_reg + 5'h01;
        shift_in_reg <= {shift_in_reg[14:0], sdio_sync_reg[2]};
        if (bit_cnt_reg == dac_cfg_pkg::INSTR_BITS - 5'h01) begin
          read_reg <= shift_in_reg[6];
          addr_out <= {shift_in_reg[5:0], sdio_sync_reg[2]};
        end
        if (bit_cnt_reg == dac_cfg_pkg::FRAME_BITS - 5'h01 && !read_reg) begin
          wdata_out <= {shift_in_reg[14:0], sdio_sync_reg[2]};
          wr_out    <= 1'b1;
        end
      end
    end
  end

  // Read data launched on falling edges so the host samples on rising ones
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      shift_out_reg <= 16'h0000;
      drive_reg     <= 1'b0;
    end else if (sden_lvl_reg) begin
      drive_reg <= 1'b0;
    end else if (sclk_fall && read_reg && bit_cnt_reg >= dac_cfg_pkg::INSTR_BITS) begin
      if (!drive_reg) shift_out_reg <= rdata_in;
      else shift_out_reg <= {shift_out_reg[14:0], 1'b0};
      drive_reg <= 1'b1;
    end
  end

  // Three-wire turns the data pin round; four-wire uses the separate output
  assign sdio_out    = shift_out_reg[15];
  assign sdo_out     = shift_out_reg[15];
  assign sdio_oe_out = drive_reg && !four_wire_in;
  assign sdo_oe_out  = drive_reg && four_wire_in;
endmodule

// ---- src/dac_datapath_config_regs.sv ----
`timescale 1ns/10ps
// Behaviour
// - Bit 15 selects word or byte input
// - Bit 14 lets conversion-clock loss mute
// - Bit 13 lets input-clock loss mute
// - Bit 12 lets FIFO collision mute
// - Bit 7 picks four-wire serial port
// - Bit 6 enables the mixer
// - Bit 5 adds 6 dB mixer gain
// - Bit 4 enables the numeric oscillator
// - Bit 3 reverses input bus order
// - Bit 1 selects two's complement input
// - Datapath control at 0x02, resets 0x7000
// - Output control at 0x03, resets 0xf000
// - Bits 15:12 set full-scale step
// - Software bit or pin enables transmit
// - Transmit off when both low or pattern test on
// - Muted outputs carry midscale code
// - Pattern checker test deactivates outputs
module dac_datapath_config_regs (
  input  wire logic        mclk_in,
  input  wire logic        sys_rst_in,
  input  wire logic        sclk_in,
  input  wire logic        sden_n_in,
  input  wire logic        sdio_in,
  output logic             sdio_out,
  output logic             sdio_oe_out,
  output logic             sdo_out,
  output logic             sdo_oe_out,
  input  wire logic        tx_enable_pin_in,
  input  wire logic        iotest_ena_in,
  input  wire logic [15:0] alarm_mask_reg_in,
  input  wire logic        dacclk_gone_in,
  input  wire logic        dataclk_gone_in,
  input  wire logic        fifo_collision_in,
  input  wire logic [15:0] din_in,
  output logic             word_wide_input_out,
  output logic             serial_four_wire_sel_out,
  output logic             mixer_enable_out,
  output logic             mixer_gain_out,
  output logic             nco_enable_out,
  output logic [4:0]       fs_step_out,
  output logic             tx_active_out,
  output logic             output_muted_out,
  output logic [15:0]      dac_code_out
);
  logic [15:0] dp_ctrl_reg;
  logic [15:0] out_ctrl_reg;
  logic        wr;
  logic [6:0]  addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic [2:0]  tx_sync_reg;
  logic        tx_pin_lvl_reg;
  logic        tx_reg;
  logic        mute_reg;
  logic        mute_next;
  logic        byte_phase_reg;
  logic [7:0]  byte_hi_reg;
  logic [15:0] word_in;
  logic        word_vld;
  logic [15:0] order_reg;
  logic        order_vld_reg;
  logic [15:0] signed_reg;
  logic [15:0] gain_reg;
  logic [15:0] dac_reg;

  // Reverse the bit order of a 16-bit word
  function automatic logic [15:0] bit_rev(input logic [15:0] w);
    logic [15:0] r;
    r = 16'h0000;
    for (int i = 0; i < 16; i++) r[i] = w[15-i];
    return r;
  endfunction

  // Signed doubling with saturation at the rails
  // Clipping beats wrapping: a wrapped peak would flip polarity
  function automatic logic [15:0] sat_double(input logic [15:0] s);
    logic [15:0] d;
    d = {s[14:0], 1'b0};
    if (s[15] != s[14]) d = s[15] ? 16'h8000 : 16'h7fff;
    return d;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Serial configuration port
  sif_slave u_sif (
    .mclk_in      (mclk_in),
    .sys_rst_in   (sys_rst_in),
    .sclk_in      (sclk_in),
    .sden_n_in    (sden_n_in),
    .sdio_in      (sdio_in),
    .sdio_out     (sdio_out),
    .sdio_oe_out  (sdio_oe_out),
    .sdo_out      (sdo_out),
    .sdo_oe_out   (sdo_oe_out),
    .four_wire_in (dp_ctrl_reg[dac_cfg_pkg::FOUR_WIRE_BIT]),
    .rdata_in     (rdata),
    .wr_out       (wr),
    .addr_out     (addr),
    .wdata_out    (wdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // datapath control storage
  // Reserved positions are not stored, so they read back zero
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) dp_ctrl_reg <= dac_cfg_pkg::DP_CTRL_RESET;
    else if (wr && addr == dac_cfg_pkg::DP_CTRL_ADDR)
      dp_ctrl_reg <= wdata & dac_cfg_pkg::DP_CTRL_MASK;
  end

  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) out_ctrl_reg <= dac_cfg_pkg::OUT_CTRL_RESET;
    else if (wr && addr == dac_cfg_pkg::OUT_CTRL_ADDR)
      out_ctrl_reg <= wdata & dac_cfg_pkg::OUT_CTRL_MASK;
  end

  // Read mux; unmapped addresses answer zero
  always_comb begin
    rdata = 16'h0000;
    if (addr == dac_cfg_pkg::DP_CTRL_ADDR) rdata = dp_ctrl_reg;
    else if (addr == dac_cfg_pkg::OUT_CTRL_ADDR) rdata = out_ctrl_reg;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control levels out to the datapath
  // input width select
  assign word_wide_input_out      = dp_ctrl_reg[dac_cfg_pkg::WORD_WIDE_BIT];
  assign serial_four_wire_sel_out = dp_ctrl_reg[dac_cfg_pkg::FOUR_WIRE_BIT];
  assign mixer_enable_out         = dp_ctrl_reg[dac_cfg_pkg::MIXER_ENA_BIT];
  assign mixer_gain_out           = dp_ctrl_reg[dac_cfg_pkg::MIXER_GAIN_BIT];
  // oscillator enable, independent of coarse mixing
  assign nco_enable_out           = dp_ctrl_reg[dac_cfg_pkg::NCO_ENA_BIT];
  assign fs_step_out = {1'b0, out_ctrl_reg[dac_cfg_pkg::FS_STEP_MSB:dac_cfg_pkg::FS_STEP_LSB]}
                       + 5'h01;
  assign tx_active_out    = tx_reg;
  assign output_muted_out = mute_reg;
  assign dac_code_out     = dac_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Transmit pin comes from off-chip: three flops, filtered level
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      tx_sync_reg    <= 3'h0;
      tx_pin_lvl_reg <= 1'b0;
    end else begin
      tx_sync_reg <= {tx_sync_reg[1:0], tx_enable_pin_in};
      if (tx_sync_reg[1] == tx_sync_reg[2]) tx_pin_lvl_reg <= tx_sync_reg[2];
    end
  end

  // software bit ORed with the pin
  // off when both sources are low or iotest_ena_in is high
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) tx_reg <= 1'b0;
    else tx_reg <= (out_ctrl_reg[dac_cfg_pkg::SW_TX_BIT] | tx_pin_lvl_reg) & ~iotest_ena_in;
  end

  ////////////////////////////////////////////////////////////////////////////
  // conversion-clock loss, input-clock loss, collision
  // A source counts only while it and the muted flag are unmasked
  always_comb begin
    mute_next = 1'b0;
    if (dp_ctrl_reg[dac_cfg_pkg::DACCLK_MUTE_BIT] && dacclk_gone_in
        && !alarm_mask_reg_in[dac_cfg_pkg::MASK_DACCLK_BIT]) mute_next = 1'b1;
    if (dp_ctrl_reg[dac_cfg_pkg::DATACLK_MUTE_BIT] && dataclk_gone_in
        && !alarm_mask_reg_in[dac_cfg_pkg::MASK_DATACLK_BIT]) mute_next = 1'b1;
    if (dp_ctrl_reg[dac_cfg_pkg::COLLISION_MUTE_BIT] && fifo_collision_in
        && !alarm_mask_reg_in[dac_cfg_pkg::MASK_COLLISION_BIT]) mute_next = 1'b1;
    if (alarm_mask_reg_in[dac_cfg_pkg::MASK_OUTPUT_BIT]) mute_next = 1'b0;
  end

  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) mute_reg <= 1'b0;
    else mute_reg <= mute_next;
  end

  ////////////////////////////////////////////////////////////////////////////
  // byte mode: high byte on low lane first, then low byte
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      byte_phase_reg <= 1'b0;
      byte_hi_reg    <= 8'h00;
    end else if (word_wide_input_out) begin
      byte_phase_reg <= 1'b0;
    end else begin
      byte_phase_reg <= ~byte_phase_reg;
      if (!byte_phase_reg) byte_hi_reg <= din_in[7:0];
    end
  end

  assign word_in  = word_wide_input_out ? din_in : {byte_hi_reg, din_in[7:0]};
  assign word_vld = word_wide_input_out | byte_phase_reg;

  // Four edges from sample to code: order, sign, gain, output
  // bus reversal applied to the assembled word
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      order_reg     <= 16'h0000;
      order_vld_reg <= 1'b0;
    end else begin
      order_vld_reg <= word_vld;
      if (word_vld) order_reg <= dp_ctrl_reg[dac_cfg_pkg::REV_BUS_BIT] ? bit_rev(word_in)
                                                                         : word_in;
    end
  end

  // offset binary flips its sign bit to become two's complement
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) signed_reg <= 16'h0000;
    else if (order_vld_reg)
      signed_reg <= dp_ctrl_reg[dac_cfg_pkg::TWOS_BIT] ? order_reg
                                                        : order_reg ^ dac_cfg_pkg::MIDSCALE_CODE;
  end

  // gain only on the mixer path; saturates rather than wraps
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) gain_reg <= 16'h0000;
    else gain_reg <= (mixer_enable_out && mixer_gain_out) ? sat_double(signed_reg) : signed_reg;
  end

  // muted or idle outputs hold midscale; converter takes offset binary
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) dac_reg <= dac_cfg_pkg::MIDSCALE_CODE;
    else if (mute_reg || !tx_reg) dac_reg <= dac_cfg_pkg::MIDSCALE_CODE;
    else dac_reg <= gain_reg ^ dac_cfg_pkg::MIDSCALE_CODE;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);

  // Register reset, write and hold checks
  a_dp_reset_val: assert property ($fell(sys_rst_in) |->
    dp_ctrl_reg == dac_cfg_pkg::DP_CTRL_RESET) else $error("datapath reset value wrong");
  a_out_reset_val: assert property ($fell(sys_rst_in) |->
    out_ctrl_reg == dac_cfg_pkg::OUT_CTRL_RESET) else $error("output reset value wrong");
  a_word_mode_wr: assert property (wr && addr == dac_cfg_pkg::DP_CTRL_ADDR |=>
    word_wide_input_out == $past(wdata[15])) else $error("input width not updated");
  a_four_wire_wr: assert property (wr && addr == dac_cfg_pkg::DP_CTRL_ADDR |=>
    serial_four_wire_sel_out == $past(wdata[7])) else $error("wire count not updated");
  a_dp_hold: assert property (!(wr && addr == dac_cfg_pkg::DP_CTRL_ADDR) |=>
    $stable(dp_ctrl_reg)) else $error("datapath register changed without write");
  a_out_hold: assert property (!(wr && addr == dac_cfg_pkg::OUT_CTRL_ADDR) |=>
    $stable(out_ctrl_reg)) else $error("output register changed without write");
  a_sw_tx_wr: assert property (wr && addr == dac_cfg_pkg::OUT_CTRL_ADDR |=>
    out_ctrl_reg[0] == $past(wdata[0])) else $error("software transmit not updated");

  // Alarm to mute checks
  a_dacclk_mute: assert property (dp_ctrl_reg[14] && dacclk_gone_in
    && !alarm_mask_reg_in[10] && !alarm_mask_reg_in[8] |=> mute_reg)
    else $error("clock loss did not mute");
  a_dataclk_mute: assert property (dp_ctrl_reg[13] && dataclk_gone_in
    && !alarm_mask_reg_in[9] && !alarm_mask_reg_in[8] |=> mute_reg)
    else $error("input clock loss did not mute");
  a_collide_mute: assert property (dp_ctrl_reg[12] && fifo_collision_in
    && !alarm_mask_reg_in[13] && !alarm_mask_reg_in[8] |=> mute_reg)
    else $error("collision did not mute");
  a_mute_release: assert property (!mute_next |=> !output_muted_out)
    else $error("muted flag held without a source");

  // Transmit and datapath checks
  a_mute_midscale: assert property (mute_reg |=> dac_code_out == 16'h8000)
    else $error("muted output not midscale");
  a_tx_on_src: assert property ((out_ctrl_reg[0] || tx_pin_lvl_reg) && !iotest_ena_in
    |=> tx_active_out) else $error("transmit not enabled");
  a_tx_off_both: assert property (!out_ctrl_reg[0] && !tx_pin_lvl_reg |=>
    !tx_active_out) else $error("transmit not disabled");
  a_iotest_off: assert property (iotest_ena_in |=> !tx_active_out ##1
    dac_code_out == 16'h8000) else $error("test mode left outputs on");
  a_fs_step: assert property (fs_step_out ==
    5'(out_ctrl_reg[15:12]) + 5'h01) else $error("full-scale step wrong");
  a_rev_order: assert property (word_vld && word_wide_input_out && dp_ctrl_reg[3]
    |=> order_reg == bit_rev($past(din_in))) else $error("bus not reversed");
  a_twos_fmt: assert property (order_vld_reg && !dp_ctrl_reg[1]
    |=> signed_reg == ($past(order_reg) ^ 16'h8000)) else $error("format conversion wrong");
  a_gain_path: assert property (mixer_enable_out && mixer_gain_out && signed_reg == 16'h0100
    |=> gain_reg == 16'h0200) else $error("mixer gain missing");
  a_mixer_nco: assert property (wr && addr == dac_cfg_pkg::DP_CTRL_ADDR |=>
    mixer_enable_out == $past(wdata[6]) && nco_enable_out == $past(wdata[4]))
    else $error("mixer or oscillator enable wrong");
  a_twos_pass: assert property (order_vld_reg && dp_ctrl_reg[1]
    |=> signed_reg == $past(order_reg)) else $error("twos complement input altered");
  a_idle_midscale: assert property (!tx_reg |=> dac_code_out == 16'h8000)
    else $error("disabled output not midscale");
  a_byte_pair: assert property ((!word_wide_input_out && !byte_phase_reg) ##1
    !word_wide_input_out |-> (word_vld && word_in[15:8] == $past(din_in[7:0])))
    else $error("byte pair not assembled high first");

  // Main scenarios reached
  c_dp_write: cover property (wr && addr == dac_cfg_pkg::DP_CTRL_ADDR);
  c_mute_seen: cover property (!mute_reg ##1 mute_reg);
  c_tx_on: cover property (!tx_active_out ##1 tx_active_out);
  c_read_drive: cover property (sdio_oe_out || sdo_oe_out);
  c_byte_mode: cover property (!word_wide_input_out && word_vld);
endmodule

// ---- verification/test_dac_datapath_config_regs.sv ----
`timescale 1ns/10ps
module test_dac_datapath_config_regs;
  localparam int HALF = 8;
  logic        mclk_in           = 1'b0;
  logic        sys_rst_in        = 1'b1;
  logic        sclk_in           = 1'b0;
  logic        sden_n_in         = 1'b1;
  logic        sdio_drv          = 1'b0;
  wire logic   sdio_in;
  logic        tx_enable_pin_in  = 1'b0;
  logic        iotest_ena_in     = 1'b0;
  logic [15:0] alarm_mask_reg_in = 16'h0000;
  logic [2:0]  alarm_src         = 3'h0;
  logic [15:0] din_in            = 16'h0000;
  logic        sdio_out, sdio_oe_out, sdo_out, sdo_oe_out;
  logic        word_wide_input_out, serial_four_wire_sel_out;
  logic        mixer_enable_out, mixer_gain_out, nco_enable_out;
  logic [4:0]  fs_step_out;
  logic        tx_active_out, output_muted_out;
  logic [15:0] dac_code_out;
  int          bad_count         = 0;
  int          samples_checked   = 0;

  // Shared three-wire data line: device wins while it drives
  assign sdio_in = sdio_oe_out ? sdio_out : sdio_drv;

  dac_datapath_config_regs u_dut (
    .mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .sclk_in(sclk_in),
    .sden_n_in(sden_n_in), .sdio_in(sdio_in), .sdio_out(sdio_out),
    .sdio_oe_out(sdio_oe_out), .sdo_out(sdo_out), .sdo_oe_out(sdo_oe_out),
    .tx_enable_pin_in(tx_enable_pin_in), .iotest_ena_in(iotest_ena_in),
    .alarm_mask_reg_in(alarm_mask_reg_in), .dacclk_gone_in(alarm_src[0]),
    .dataclk_gone_in(alarm_src[1]), .fifo_collision_in(alarm_src[2]), .din_in(din_in),
    .word_wide_input_out(word_wide_input_out),
    .serial_four_wire_sel_out(serial_four_wire_sel_out),
    .mixer_enable_out(mixer_enable_out), .mixer_gain_out(mixer_gain_out),
    .nco_enable_out(nco_enable_out), .fs_step_out(fs_step_out),
    .tx_active_out(tx_active_out), .output_muted_out(output_muted_out),
    .dac_code_out(dac_code_out)
  );

  // 10 MHz system clock
  always #50 mclk_in = ~mclk_in;

  ////////////////////////////////////////////////////////////////////////////////
  // Closing report, shared by the main sequence and any expired wait
  task automatic results;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_bit(input string what, input logic exp, input logic got);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %b seen %b", what, exp, got);
    end
  endtask

  // Inputs always move the same small delay after the rising edge
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_in);
    #5;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // One serial frame; slow sclk keeps the synchroniser's filter happy
  task automatic sif(input logic rd, input logic [6:0] addr, input logic [15:0] wdata,
                     output logic [15:0] rdata);
    logic [23:0] frame;
    frame = {rd, addr, wdata};
    rdata = 16'h0000;
    sden_n_in = 1'b0;
    cyc(HALF);
    for (int i = 0; i < 24; i++) begin
      sdio_drv = frame[23-i];
      cyc(HALF);
      // Host samples read data just before its rising sclk
      if (i >= 8) begin
        rdata = {rdata[14:0], serial_four_wire_sel_out ? sdo_out : sdio_out};
      end
      if (rd && i == 8) begin
        chk_bit("read pin enable", 1'b1, serial_four_wire_sel_out ? sdo_oe_out : sdio_oe_out);
      end
      sclk_in = 1'b1;
      cyc(HALF);
      sclk_in = 1'b0;
    end
    cyc(HALF);
    sden_n_in = 1'b1;
    sdio_drv = 1'b0;
    cyc(8);
  endtask

  task automatic wr(input logic [6:0] addr, input logic [15:0] data);
    logic [15:0] dummy;
    sif(1'b0, addr, data, dummy);
  endtask

  task automatic rd(input logic [6:0] addr, input logic [15:0] exp, input string what);
    logic [15:0] got;
    sif(1'b1, addr, 16'h0000, got);
    chk(what, exp, got);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Hold a sample steady long enough for the whole output pipeline
  task automatic dp_try(input logic [15:0] dpv, input logic [15:0] din,
                        input logic [15:0] exp);
    wr(dac_cfg_pkg::DP_CTRL_ADDR, dpv);
    din_in = din;
    cyc(8);
    chk("converter code", exp, dac_code_out);
  endtask

  // Raise one alarm source and see whether the outputs go to midscale
  task automatic mute_try(input int k, input logic [15:0] dpv, input logic [15:0] mask,
                          input logic exp);
    wr(dac_cfg_pkg::DP_CTRL_ADDR, dpv);
    alarm_mask_reg_in = mask;
    alarm_src[k] = 1'b1;
    cyc(3);
    chk_bit("muted flag", exp, output_muted_out);
    chk("muted code", exp ? dac_cfg_pkg::MIDSCALE_CODE : 16'h1234, dac_code_out);
    alarm_src[k] = 1'b0;
    alarm_mask_reg_in = 16'h0000;
    cyc(6);
    chk_bit("mute released", 1'b0, output_muted_out);
  endtask

  // Bounded wait on the transmit flag; expiry ends the run
  task automatic wait_tx(input logic exp);
    int n;
    n = 0;
    while (tx_active_out !== exp && n < 12) begin
      cyc(1);
      n++;
    end
    if (tx_active_out !== exp) begin
      bad_count++;
      $display("[ERR] transmit flag expected %b seen %b", exp, tx_active_out);
      results();
    end else begin
      chk_bit("transmit flag", exp, tx_active_out);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  int          k;
  logic [15:0] ena [3];
  logic [15:0] msk [3];

  initial begin
    ena = '{16'h4000, 16'h2000, 16'h1000};
    msk = '{16'h0400, 16'h0200, 16'h2000};
    cyc(12);
    sys_rst_in = 1'b0;
    cyc(2);
    chk("full scale", 16'h0010, {11'h000, fs_step_out});
    chk("idle code", 16'h8000, dac_code_out);
    chk_bit("idle transmit", 1'b0, tx_active_out);
    rd(dac_cfg_pkg::DP_CTRL_ADDR, 16'h7000, "datapath reset");
    rd(dac_cfg_pkg::OUT_CTRL_ADDR, 16'hf000, "output reset");
    // field boundaries; reserved bits always written as zero
    wr(dac_cfg_pkg::OUT_CTRL_ADDR, 16'h0000);
    chk("full scale low", 16'h0001, {11'h000, fs_step_out});
    rd(dac_cfg_pkg::OUT_CTRL_ADDR, 16'h0000, "output reserved");
    wr(dac_cfg_pkg::OUT_CTRL_ADDR, 16'h5000);
    chk("full scale mid", 16'h0006, {11'h000, fs_step_out});
    // pin alone, then software bit alone
    tx_enable_pin_in = 1'b1;
    wait_tx(1'b1);
    tx_enable_pin_in = 1'b0;
    wait_tx(1'b0);
    wr(dac_cfg_pkg::OUT_CTRL_ADDR, 16'hf001);
    wait_tx(1'b1);
    tx_enable_pin_in = 1'b1;
    iotest_ena_in = 1'b1;
    cyc(3);
    chk_bit("test transmit", 1'b0, tx_active_out);
    chk("test code", 16'h8000, dac_code_out);
    iotest_ena_in = 1'b0;
    tx_enable_pin_in = 1'b0;
    wait_tx(1'b1);
    // mode bits land on their outputs; four-wire read via sdo
    wr(dac_cfg_pkg::DP_CTRL_ADDR, 16'hf0fa);
    rd(dac_cfg_pkg::DP_CTRL_ADDR, 16'hf0fa, "datapath all ones");
    chk("mode outputs", 16'h001f, {11'h000, word_wide_input_out, serial_four_wire_sel_out,
        mixer_enable_out, mixer_gain_out, nco_enable_out});
    wr(dac_cfg_pkg::DP_CTRL_ADDR, 16'h0000);
    rd(dac_cfg_pkg::DP_CTRL_ADDR, 16'h0000, "datapath cleared");
    chk("mode outputs clear", 16'h0000, {11'h000, word_wide_input_out,
        serial_four_wire_sel_out, mixer_enable_out, mixer_gain_out, nco_enable_out});
    dp_try(16'h8000, 16'h1234, 16'h1234);
    dp_try(16'h8002, 16'h1234, 16'h9234);
    dp_try(16'h800a, 16'h0003, 16'h4000);
    dp_try(16'h8062, 16'h1000, 16'ha000);
    dp_try(16'h8022, 16'h1000, 16'h9000);
    dp_try(16'h0000, 16'h125a, 16'h5a5a);
    // Unmapped place ignores writes and reads zero
    wr(7'h05, 16'hffff);
    rd(7'h05, 16'h0000, "unmapped read");
    rd(dac_cfg_pkg::DP_CTRL_ADDR, 16'h0000, "datapath untouched");
    // each source: live, masked, disabled, output flag masked
    din_in = 16'h1234;
    for (k = 0; k < 3; k++) begin
      mute_try(k, 16'hf000, 16'h0000, 1'b1);
      mute_try(k, 16'hf000, msk[k], 1'b0);
      mute_try(k, 16'hf000 & ~ena[k], 16'h0000, 1'b0);
      mute_try(k, 16'hf000, 16'h0100, 1'b0);
    end
    results();
  end
endmodule
